/* File: quad_decoder_accum_events.sv */
// Quadrature decoder accumulators, snapshot tasks and event flags.
// Assumes an AXI4-Lite master on aclk and phase pins from an encoder.
// Function
// - Displacement task write of 1 snapshots accumulator then zeroes it.
// - Displacement snapshot and zeroing are indivisible; no counted step is lost.
// - Double task write of 1 snapshots double accumulator then zeroes it.
// - Double snapshot and zeroing are indivisible; no double transition is lost.
// - Each new motion sample written raises the sample-ready flag.
// - After the report period count of samples, evaluate report-ready.
// - Report-ready is raised only when the displacement accumulator is non-zero.
// - Overflow of either accumulator raises the overflow flag.
// - While enabled, a new motion sample is taken every sample period.
// - Displacement accumulator adds up the valid transitions of each sample.
//
// Chosen here: the AXI4-Lite slave port.
module quad_decoder_accum_events #(
   parameter int ACC_W = quad_pkg::ACC_W,
   parameter int DBL_W = quad_pkg::DBL_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [quad_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [quad_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic phase_a,
   input wire logic phase_b,
   output logic irq
);
   import quad_pkg::*;

   localparam logic [PER_W-1:0] ONE_P = PER_W'(1);

   // Bus state
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   rd_state_t rd_state_r, rd_state_nxt;
   logic wr_fire, ar_take;
   logic [11:0] wa, ra;

   // Core state
   logic [1:0] ab_s, prev_ab_r, prev_ab_nxt;
   logic enable_r, enable_nxt;
   logic [PER_W-1:0] sper_r, sper_nxt, rper_r, rper_nxt;
   logic [PER_W-1:0] scnt_r, scnt_nxt, rcnt_r, rcnt_nxt, rinc;
   logic [SMP_W-1:0] sample_r, sample_nxt, smp_val;
   logic [ACC_W-1:0] acc_r, acc_nxt, dsnap_r, dsnap_nxt, acc_upd;
   logic [DBL_W-1:0] dbl_r, dbl_nxt, dbsnap_r, dbsnap_nxt, dbl_upd;
   logic [ACC_W:0] acc_sum;
   logic [DBL_W:0] dbl_sum;
   logic [NUM_EV-1:0] inten_r, inten_nxt, ev_set, ev_clr, flags;
   logic irq_nxt;
   logic tick, single, dbl_step, fwd, ovf_acc, ovf_dbl, rep_end;
   logic task_disp, task_dbl;
   logic [1:0] chg, gp, gc, gd;
   logic [31:0] sper_m, rper_m, inten_m;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] o;
      o = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            o[8*i +: 8] = d[8*i +: 8];
         end
      end
      return o;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      case ({a[11:2], 2'b00})
         OFF_SNAP_DISP, OFF_SNAP_DBL, OFF_EV_SAMPLE, OFF_EV_REPORT,
         OFF_EV_OVF, OFF_ENABLE, OFF_SPER, OFF_SAMPLE, OFF_RPER, OFF_ACC,
         OFF_DSNAP, OFF_DBL, OFF_DBSNAP, OFF_IRQ_STAT, OFF_IRQ_CLR,
         OFF_IRQ_EN: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Phase pins come from the encoder, outside this clock
   sync2 #(.W(2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({phase_a, phase_b}),
      .q(ab_s)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_EV; g++) begin : gen_ev
         event_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(ev_set[g]),
            .clr(ev_clr[g]),
            .flag_r(flags[g])
         );
      end
   endgenerate

   // AXI4-Lite slave
   always_comb begin
      wa = {waddr_r[11:2], 2'b00};
      ra = {araddr[11:2], 2'b00};
      wr_fire = aw_full_r & w_full_r & ~bvalid;
      ar_take = arvalid & arready;
      aw_full_nxt = wr_fire ? 1'b0 : (aw_full_r | (awvalid & awready));
      w_full_nxt = wr_fire ? 1'b0 : (w_full_r | (wvalid & wready));
      waddr_nxt = (awvalid & awready) ? awaddr : waddr_r;
      wdata_nxt = (wvalid & wready) ? wdata : wdata_r;
      wstrb_nxt = (wvalid & wready) ? wstrb : wstrb_r;
      bvalid_nxt = wr_fire | (bvalid & ~bready);
      bresp_nxt = bresp;
      if (wr_fire) begin
         bresp_nxt = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end
      // One write at a time: both channels close until the response is taken
      awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
      wready_nxt = ~w_full_nxt & ~bvalid_nxt;
      rd_state_nxt = rd_state_r;
      rvalid_nxt = rvalid;
      rdata_nxt = rdata;
      rresp_nxt = rresp;
      case (rd_state_r)
         RD_IDLE: begin
            if (ar_take) begin
               rd_state_nxt = RD_RESP;
               rvalid_nxt = 1'b1;
               rresp_nxt = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
               rdata_nxt = 32'h00000000;
               case (ra)
                  OFF_EV_SAMPLE: rdata_nxt[0] = flags[EV_SAMPLE];
                  OFF_EV_REPORT: rdata_nxt[0] = flags[EV_REPORT];
                  OFF_EV_OVF: rdata_nxt[0] = flags[EV_OVF];
                  OFF_ENABLE: rdata_nxt[0] = enable_r;
                  OFF_SPER: rdata_nxt[PER_W-1:0] = sper_r;
                  OFF_SAMPLE: rdata_nxt = 32'(signed'(sample_r));
                  OFF_RPER: rdata_nxt[PER_W-1:0] = rper_r;
                  OFF_ACC: rdata_nxt = 32'(signed'(acc_r));
                  OFF_DSNAP: rdata_nxt = 32'(signed'(dsnap_r));
                  OFF_DBL: rdata_nxt[DBL_W-1:0] = dbl_r;
                  OFF_DBSNAP: rdata_nxt[DBL_W-1:0] = dbsnap_r;
                  OFF_IRQ_STAT: rdata_nxt[NUM_EV-1:0] = flags;
                  OFF_IRQ_EN: rdata_nxt[NUM_EV-1:0] = inten_r;
                  default: rdata_nxt = 32'h00000000;
               endcase
            end
         end
         RD_RESP: begin
            if (rready) begin
               rd_state_nxt = RD_IDLE;
               rvalid_nxt = 1'b0;
            end
         end
         default: begin
            rd_state_nxt = RD_IDLE;
            rvalid_nxt = 1'b0;
         end
      endcase
      arready_nxt = (rd_state_nxt == RD_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rd_state_r <= RD_IDLE;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready <= awready_nxt;
         wready <= wready_nxt;
         bvalid <= bvalid_nxt;
         bresp <= bresp_nxt;
         rd_state_r <= rd_state_nxt;
         arready <= arready_nxt;
         rvalid <= rvalid_nxt;
         rdata <= rdata_nxt;
         rresp <= rresp_nxt;
      end
   end

   // Decoder core
   always_comb begin
      task_disp = wr_fire & (wa == OFF_SNAP_DISP) & wstrb_r[0] & wdata_r[0];
      task_dbl = wr_fire & (wa == OFF_SNAP_DBL) & wstrb_r[0] & wdata_r[0];
      tick = enable_r & (scnt_r >= sper_r);
      scnt_nxt = (!enable_r || tick) ? '0 : scnt_r + ONE_P;
      chg = prev_ab_r ^ ab_s;
      gp = {prev_ab_r[1], ^prev_ab_r};
      gc = {ab_s[1], ^ab_s};
      gd = gc - gp;
      fwd = (gd == 2'h1);
      single = tick & (chg == 2'h1 || chg == 2'h2);
      dbl_step = tick & (chg == 2'h3);
      if (chg == 2'h3) begin
         smp_val = SMP_DOUBLE;
      end else if (chg == 2'h0) begin
         smp_val = SMP_NONE;
      end else begin
         smp_val = fwd ? SMP_FWD : SMP_REV;
      end
      acc_sum = {acc_r[ACC_W-1], acc_r} + (fwd ? (ACC_W+1)'(1) : '1);
      ovf_acc = single & (acc_sum[ACC_W] != acc_sum[ACC_W-1]);
      dbl_sum = {1'b0, dbl_r} + (DBL_W+1)'(1);
      ovf_dbl = dbl_step & dbl_sum[DBL_W];
      // Saturate on overflow: the stale value beats a wrapped one
      acc_upd = (single & ~ovf_acc) ? acc_sum[ACC_W-1:0] : acc_r;
      dbl_upd = (dbl_step & ~ovf_dbl) ? dbl_sum[DBL_W-1:0] : dbl_r;
      // This cycle's step lands in the snapshot, so none slips away
      dsnap_nxt = task_disp ? acc_upd : dsnap_r;
      acc_nxt = task_disp ? '0 : acc_upd;
      dbsnap_nxt = task_dbl ? dbl_upd : dbsnap_r;
      dbl_nxt = task_dbl ? '0 : dbl_upd;
      prev_ab_nxt = tick ? ab_s : prev_ab_r;
      sample_nxt = tick ? smp_val : sample_r;
      rinc = rcnt_r + ONE_P;
      rep_end = tick & (rinc >= rper_r);
      rcnt_nxt = !enable_r ? '0 : rep_end ? '0 : tick ? rinc : rcnt_r;
      ev_set[EV_SAMPLE] = tick;
      ev_set[EV_REPORT] = rep_end & (acc_upd != '0);
      ev_set[EV_OVF] = ovf_acc | ovf_dbl;
      for (int i = 0; i < NUM_EV; i++) begin
         ev_clr[i] = wr_fire & wstrb_r[0] & wa == OFF_IRQ_CLR & wdata_r[i];
      end
      ev_clr[EV_SAMPLE] |= wr_fire & wa == OFF_EV_SAMPLE & wstrb_r[0]
         & ~wdata_r[0];
      ev_clr[EV_REPORT] |= wr_fire & wa == OFF_EV_REPORT & wstrb_r[0]
         & ~wdata_r[0];
      ev_clr[EV_OVF] |= wr_fire & wa == OFF_EV_OVF & wstrb_r[0]
         & ~wdata_r[0];
      enable_nxt = enable_r;
      sper_nxt = sper_r;
      rper_nxt = rper_r;
      inten_nxt = inten_r;
      // A call result cannot be sliced, so the merged words land here first
      sper_m = merge(32'(sper_r), wdata_r, wstrb_r);
      rper_m = merge(32'(rper_r), wdata_r, wstrb_r);
      inten_m = merge(32'(inten_r), wdata_r, wstrb_r);
      if (wr_fire && wstrb_r[0] && wa == OFF_ENABLE) begin
         enable_nxt = wdata_r[0];
      end
      if (wr_fire && wa == OFF_SPER) begin
         sper_nxt = sper_m[PER_W-1:0];
      end
      if (wr_fire && wa == OFF_RPER) begin
         rper_nxt = rper_m[PER_W-1:0];
      end
      if (wr_fire && wa == OFF_IRQ_EN) begin
         inten_nxt = inten_m[NUM_EV-1:0];
      end
      irq_nxt = |(flags & inten_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= 1'b0;
         sper_r <= SPER_RST;
         rper_r <= RPER_RST;
         scnt_r <= '0;
         rcnt_r <= '0;
         prev_ab_r <= 2'h0;
         sample_r <= SMP_NONE;
         acc_r <= '0;
         dsnap_r <= '0;
         dbl_r <= '0;
         dbsnap_r <= '0;
         inten_r <= '0;
         irq <= 1'b0;
      end else begin
         enable_r <= enable_nxt;
         sper_r <= sper_nxt;
         rper_r <= rper_nxt;
         scnt_r <= scnt_nxt;
         rcnt_r <= rcnt_nxt;
         prev_ab_r <= prev_ab_nxt;
         sample_r <= sample_nxt;
         acc_r <= acc_nxt;
         dsnap_r <= dsnap_nxt;
         dbl_r <= dbl_nxt;
         dbsnap_r <= dbsnap_nxt;
         inten_r <= inten_nxt;
         irq <= irq_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence disp_task_s;
      task_disp ##1 (acc_r == '0);
   endsequence

   disp_clear_a: assert property (task_disp |-> disp_task_s)
      else $error("accumulator not zeroed by snapshot task");
   disp_atomic_a: assert property (task_disp |=>
      dsnap_r == $past(acc_upd)) else $error("displacement step lost");
   dbl_clear_a: assert property (task_dbl |=> dbl_r == '0)
      else $error("double accumulator not zeroed");
   dbl_atomic_a: assert property (task_dbl |=>
      dbsnap_r == $past(dbl_upd)) else $error("double step lost");
   sample_flag_a: assert property (tick |=> flags[EV_SAMPLE])
      else $error("sample flag not raised");
   report_when_a: assert property ($rose(flags[EV_REPORT]) |->
      $past(rep_end)) else $error("report flag outside period end");
   report_nonzero_a: assert property (rep_end && acc_upd != '0
      |=> flags[EV_REPORT]) else $error("report flag missing");
   ovf_flag_a: assert property (ovf_acc || ovf_dbl
      |=> flags[EV_OVF] && acc_r == $past(acc_r) || $past(task_disp))
      else $error("overflow not flagged");
   sample_period_a: assert property (enable_r && enable_nxt && tick
      |=> scnt_r == '0 && (sper_r == '0 || !tick))
      else $error("sample period not kept");
   acc_step_a: assert property (single && !ovf_acc && !task_disp
      |=> acc_r != $past(acc_r)) else $error("transition not added");
   irq_level_a: assert property (|(flags & inten_r) |=> irq)
      else $error("interrupt not raised");
endmodule

/* File: quad_pkg.sv */
// Constants shared by the quadrature accumulator block and its helpers.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package quad_pkg;
   localparam int ADDR_W = 12;
   localparam int PER_W = 16;
   localparam int ACC_W = 16;
   localparam int DBL_W = 8;
   localparam int SMP_W = 3;
   localparam int NUM_EV = 3;
   localparam int EV_SAMPLE = 0;
   localparam int EV_REPORT = 1;
   localparam int EV_OVF = 2;
   localparam logic [11:0] OFF_SNAP_DISP = 12'h00C;
   localparam logic [11:0] OFF_SNAP_DBL = 12'h010;
   localparam logic [11:0] OFF_EV_SAMPLE = 12'h100;
   localparam logic [11:0] OFF_EV_REPORT = 12'h104;
   localparam logic [11:0] OFF_EV_OVF = 12'h108;
   localparam logic [11:0] OFF_ENABLE = 12'h500;
   localparam logic [11:0] OFF_SPER = 12'h508;
   localparam logic [11:0] OFF_SAMPLE = 12'h50C;
   localparam logic [11:0] OFF_RPER = 12'h510;
   localparam logic [11:0] OFF_ACC = 12'h514;
   localparam logic [11:0] OFF_DSNAP = 12'h518;
   localparam logic [11:0] OFF_DBL = 12'h544;
   localparam logic [11:0] OFF_DBSNAP = 12'h548;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h600;
   localparam logic [11:0] OFF_IRQ_CLR = 12'h604;
   localparam logic [11:0] OFF_IRQ_EN = 12'h608;
   localparam logic [15:0] SPER_RST = 16'h0009;
   localparam logic [15:0] RPER_RST = 16'h000A;
   localparam logic [2:0] SMP_NONE = 3'h0;
   localparam logic [2:0] SMP_FWD = 3'h1;
   localparam logic [2:0] SMP_DOUBLE = 3'h2;
   localparam logic [2:0] SMP_REV = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;
endpackage

/* File: sync2.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the inputs are slow levels; no pulse is guaranteed to pass.
module sync2 #(
   parameter int W = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= meta_nxt;
         q <= q_nxt;
      end
   end
endmodule

/* File: event_flag.sv */
// One sticky event flag: hardware sets, software clears.
// Assumes set and clr are single-cycle requests on aclk.
module event_flag (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set,
   input wire logic clr,
   output logic flag_r
);
   logic flag_nxt;

   // Set beats clear so an event in the clearing cycle is kept
   always_comb begin
      flag_nxt = set | (flag_r & ~clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   flag_set_a: assert property (set |=> flag_r)
      else $error("event flag not set");
   flag_hold_a: assert property (flag_r && !clr |=> flag_r)
      else $error("event flag dropped without clear");
endmodule

/* File: enc_model.sv */
// Encoder model driving the two phase pins in gray order.
// Assumes the bench calls move() from one process at a time.
module enc_model #(
   parameter int GAP = 40
) (
   input wire logic aclk,
   output logic phase_a,
   output logic phase_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pos;
   initial begin
      pos = 2'h0;
      phase_a = 1'b0;
      phase_b = 1'b0;
   end
   // Steps: 1 forward, 3 reverse, 2 a double jump
   // Slow steps so that every sample sees at most one change
   task automatic move(input int n, input logic [1:0] stp);
      int i;
      for (i = 0; i < n; i++) begin
         pos = pos + stp;
         @(posedge aclk);
         phase_a <= pos[1];
         phase_b <= pos[1] ^ pos[0];
         repeat (GAP) @(posedge aclk);
      end
   endtask
endmodule

/* File: tb_quad_decoder_accum_events.sv */
// Bench for the accumulator and event block over AXI4-Lite.
// Assumes the encoder model on the phase pins; accumulator kept 4 bits.
module tb_quad_decoder_accum_events;
   timeunit 1ns;
   timeprecision 1ps;
   import quad_pkg::*;
   localparam int AW = 4;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, phase_a, phase_b, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   int bad_count = 0;
   int num_checks = 0;
   quad_decoder_accum_events #(.ACC_W(AW)) DUT (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .phase_a(phase_a), .phase_b(phase_b), .irq(irq));
   enc_model enc (.aclk(aclk), .phase_a(phase_a), .phase_b(phase_b));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic limit(input int n);
      if (n >= 200) begin
         bad_count++;
         $display("BAD handshake wait ran out");
         wrap_up();
      end
   endtask
   // Address and data offered together; each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ap, dp;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ap = 1'b1;
      dp = 1'b1;
      n = 0;
      while ((ap || dp) && n < 200) begin
         @(posedge aclk);
         n++;
         if (ap && awready === 1'b1) begin
            awvalid <= 1'b0;
            ap = 1'b0;
         end
         if (dp && wready === 1'b1) begin
            wvalid <= 1'b0;
            dp = 1'b0;
         end
      end
      limit(n);
      while (bvalid !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      limit(n);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 200);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 200) begin
         @(posedge aclk);
         n++;
      end
      limit(n);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic t_reset();
      rdr(OFF_EV_SAMPLE);
      chk("sample flag rst", rd, 32'h00000000);
      rdr(OFF_EV_REPORT);
      chk("report flag rst", rd, 32'h00000000);
      rdr(OFF_EV_OVF);
      chk("ovf flag rst", rd, 32'h00000000);
      chk("irq rst", {31'h0, irq}, 32'h00000000);
      rdr(12'h0FC);
      chk("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      wr(12'h0FC, 32'h00000001);
      chk("unmapped wresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      rdr(OFF_SPER);
      chk("period rst", rd, {16'h0000, SPER_RST});
      rdr(OFF_RPER);
      chk("report count rst", rd, {16'h0000, RPER_RST});
      rdr(OFF_SAMPLE);
      chk("sample rst", rd, 32'h00000000);
   endtask
   // Flag stays set after sampling stops, then software clears it
   task automatic t_sticky();
      wr(OFF_ENABLE, 32'h00000001);
      chk("wresp okay", {30'h0, rs}, {30'h0, RESP_OKAY});
      repeat (40) @(posedge aclk);
      wr(OFF_ENABLE, 32'h00000000);
      repeat (30) @(posedge aclk);
      rdr(OFF_EV_SAMPLE);
      chk("sample flag", rd, 32'h00000001);
      wr(OFF_EV_SAMPLE, 32'h00000000);
      rdr(OFF_EV_SAMPLE);
      chk("sample flag clr", rd, 32'h00000000);
   endtask
   task automatic t_irq();
      wr(OFF_IRQ_EN, 32'h00000001);
      wr(OFF_ENABLE, 32'h00000001);
      repeat (40) @(posedge aclk);
      wr(OFF_ENABLE, 32'h00000000);
      repeat (3) @(posedge aclk);
      chk("irq set", {31'h0, irq}, 32'h00000001);
      rdr(OFF_IRQ_STAT);
      chk("status", rd & 32'h1, 32'h00000001);
      wr(OFF_IRQ_EN, 32'h00000000);
      repeat (3) @(posedge aclk);
      chk("irq masked", {31'h0, irq}, 32'h00000000);
      wr(OFF_IRQ_EN, 32'h00000001);
      repeat (3) @(posedge aclk);
      chk("irq unmasked", {31'h0, irq}, 32'h00000001);
      wr(OFF_IRQ_CLR, 32'h00000001);
      repeat (3) @(posedge aclk);
      chk("irq cleared", {31'h0, irq}, 32'h00000000);
   endtask
   // Snapshot taken mid-motion: snapshot plus remainder is the total
   task automatic t_disp();
      logic [31:0] snap;
      wr(OFF_ENABLE, 32'h00000001);
      wr(OFF_SNAP_DISP, 32'h00000001);
      enc.move(3, 2'h1);
      repeat (30) @(posedge aclk);
      rdr(OFF_ACC);
      chk("acc fwd", rd & 32'hF, 32'h00000003);
      wr(OFF_SNAP_DISP, 32'h00000001);
      rdr(OFF_DSNAP);
      chk("snap", rd & 32'hF, 32'h00000003);
      rdr(OFF_ACC);
      chk("acc zero", rd & 32'hF, 32'h00000000);
      enc.move(2, 2'h3);
      repeat (30) @(posedge aclk);
      rdr(OFF_ACC);
      chk("acc rev", rd & 32'hF, 32'h0000000E);
      wr(OFF_SNAP_DISP, 32'h00000001);
      fork
         enc.move(6, 2'h1);
         begin
            repeat (125) @(posedge aclk);
            wr(OFF_SNAP_DISP, 32'h00000001);
         end
      join
      repeat (30) @(posedge aclk);
      rdr(OFF_DSNAP);
      snap = rd & 32'hF;
      rdr(OFF_ACC);
      chk("split sum", snap + (rd & 32'hF), 32'h00000006);
   endtask
   task automatic t_report();
      wr(OFF_SNAP_DISP, 32'h00000001);
      wr(OFF_EV_REPORT, 32'h00000000);
      repeat (250) @(posedge aclk);
      rdr(OFF_EV_REPORT);
      chk("report idle", rd, 32'h00000000);
      enc.move(1, 2'h1);
      repeat (250) @(posedge aclk);
      rdr(OFF_EV_REPORT);
      chk("report moved", rd, 32'h00000001);
   endtask
   // Nine steps into a 4-bit signed count saturates at 7
   task automatic t_ovf();
      wr(OFF_SNAP_DISP, 32'h00000001);
      wr(OFF_EV_OVF, 32'h00000000);
      enc.move(9, 2'h1);
      repeat (30) @(posedge aclk);
      rdr(OFF_EV_OVF);
      chk("ovf flag", rd, 32'h00000001);
      wr(OFF_SNAP_DISP, 32'h00000001);
      rdr(OFF_DSNAP);
      chk("snap sat", rd & 32'hF, 32'h00000007);
   endtask
   task automatic t_double();
      wr(OFF_SNAP_DBL, 32'h00000001);
      enc.move(2, 2'h2);
      repeat (30) @(posedge aclk);
      rdr(OFF_DBL);
      chk("dbl acc", rd & 32'hFF, 32'h00000002);
      wr(OFF_SNAP_DBL, 32'h00000001);
      rdr(OFF_DBSNAP);
      chk("dbl snap", rd & 32'hFF, 32'h00000002);
      rdr(OFF_DBL);
      chk("dbl zero", rd & 32'hFF, 32'h00000000);
   endtask
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h00000000;
      wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_sticky();
      t_irq();
      t_disp();
      t_report();
      t_ovf();
      t_double();
      wrap_up();
   end
endmodule
